// ==== design/dfc_pkg.sv ====
// Package: register map, field layout and types of the frame control block
package dfc_pkg;

    localparam int          ADDR_W     = 20;
    localparam int          DATA_W     = 32;
    localparam int          REG_W      = 16;
    localparam int          SEL_W      = 5;
    localparam int          NUM_CODES  = 32;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_HALT   = 16'hF400;
    localparam logic [15:0] IDX_TICK   = 16'hF401;
    localparam logic [15:0] IDX_STAT   = 16'hF4FF;
    localparam logic [ADDR_W-1:0] ADDR_HALT = {2'h0, IDX_HALT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_TICK = {2'h0, IDX_TICK, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};

    // Field positions and reset values
    localparam int          HALT_BIT   = 0;
    localparam logic        HALT_RST   = 1'h0;
    localparam logic [SEL_W-1:0] SEL_RST = 5'h02;
    localparam int          STAT_HALTED = 0;
    localparam int          STAT_DRAIN  = 1;
    localparam int          STAT_MASK   = 2;

    // Frame tick source codes
    localparam logic [SEL_W-1:0] CODE_CG1_LO = 5'h00;
    localparam logic [SEL_W-1:0] CODE_CG2_LO = 5'h05;
    localparam logic [SEL_W-1:0] CODE_IN_LO  = 5'h08;
    localparam logic [SEL_W-1:0] CODE_OUT_LO = 5'h0C;
    localparam logic [SEL_W-1:0] CODE_SPDIF  = 5'h10;

    // Tick sources, packed so that bit n answers code n
    typedef struct packed {
        logic       spdif;
        logic [3:0] out_port;
        logic [3:0] in_port;
        logic [2:0] cg2;
        logic [4:0] cg1;
    } dfc_tick_src_t;

    typedef struct packed {
        logic run_en;
        logic audio_en;
        logic irq_mask;
    } dfc_core_ctl_t;

    typedef enum logic [1:0] {
        DFC_RUN,
        DFC_DRAIN,
        DFC_HALTED
    } dfc_halt_state_t;

endpackage

// ==== design/dfc_tick_mux.sv ====
// Frame tick source selector
module dfc_tick_mux (
    input  wire logic [dfc_pkg::SEL_W-1:0] sel,
    input  wire dfc_pkg::dfc_tick_src_t    src,
    output logic                           tick
);

    localparam int SRC_W = $bits(dfc_pkg::dfc_tick_src_t);

    logic [dfc_pkg::NUM_CODES-1:0] vec;
    logic [dfc_pkg::NUM_CODES-1:0] hit;

    // Codes above the S/PDIF code carry no source
    assign vec = {{(dfc_pkg::NUM_CODES - SRC_W){1'b0}}, src}; // [RULE17]

    // One decode term per code
    for (genvar g = 0; g < dfc_pkg::NUM_CODES; g++) begin : g_code
        assign hit[g] = (sel == dfc_pkg::SEL_W'(g)) & vec[g]; // [RULE9] [RULE10] [RULE11] [RULE12] [RULE13] [RULE16]
    end

    assign tick = |hit;

endmodule

// ==== design/dfc_top.sv ====
// Core low-power halt and frame tick source selection with APB registers
//
// Operation
// RULE1: A halt request raised while a sample or block is in flight waits for it to finish first.
// RULE2: After setting halt during processing, software waits one sample period before other writes.
// RULE3: With block processing, software waits one block plus one sample period before other writes.
// RULE4: While halt is requested or held, every interrupt to the core is masked.
// RULE5: While halted, audio is gated off and core processing is stopped.
// RULE6: The halt control is bit 0, reset 0; 0 runs with interrupts, 1 halts with interrupts masked.
// RULE7: The selected tick marks the start of every core audio frame.
// RULE8: The tick source field is bits 4 to 0, reset 0x02, and sets the processing rate.
// RULE9: Codes 0 to 4 pick the first generator at quarter, half, one, two and four times base rate.
// RULE10: Codes 5 and 6 pick the second generator's quarter and half outputs.
// RULE11: Codes 8 to 11 pick input serial ports 0 to 3.
// RULE12: Codes 12 to 15 pick output serial ports 0 to 3.
// RULE13: Code 16 picks the tick recovered from the S/PDIF receiver.
// RULE14: An external tick comes from a serial port's left/right frame clock.
// RULE15: Audio not synchronous to the tick must go through a sample_rate_converter.
// RULE16: Code 7 picks the second generator's unity output.
// RULE17: Codes 17 to 31 are reserved and give no tick.
module dfc_top (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          pclken,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [dfc_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [dfc_pkg::DATA_W-1:0]    pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [dfc_pkg::DATA_W-1:0]    prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          core_busy,
    input  wire dfc_pkg::dfc_tick_src_t        tick_src,
    output logic                               frame_tick,
    output logic                               core_frame_irq,
    output dfc_pkg::dfc_core_ctl_t             core_ctl,
    output logic                               core_halted
);

    // Register state
    logic                         halt_q;
    logic                         halt_d;
    logic [dfc_pkg::SEL_W-1:0]    sel_q;
    logic [dfc_pkg::SEL_W-1:0]    sel_d;

    // Bus answer state
    logic [dfc_pkg::DATA_W-1:0]   rdata_q;
    logic [dfc_pkg::DATA_W-1:0]   rdata_d;
    logic                         slverr_q;
    logic                         slverr_d;

    // Halt sequencer state
    dfc_pkg::dfc_halt_state_t     state_q;
    dfc_pkg::dfc_halt_state_t     state_d;

    // Frame tick state
    logic                         tick_q;
    logic                         tick_d;
    logic                         irq_q;
    logic                         irq_d;

    logic                         sel_tick;
    logic                         setup;
    logic                         access;
    logic                         hit_halt;
    logic                         hit_tick;
    logic                         hit_stat;
    logic                         wr_halt;
    logic                         wr_tick;
    logic [dfc_pkg::REG_W-1:0]    stat_word;

    // Address decode
    assign setup    = pclken & psel & ~penable;
    assign access   = pclken & psel & penable;
    assign hit_halt = (paddr == dfc_pkg::ADDR_HALT);
    assign hit_tick = (paddr == dfc_pkg::ADDR_TICK);
    assign hit_stat = (paddr == dfc_pkg::ADDR_STAT);
    assign wr_halt  = access & pwrite & hit_halt & pstrb[0];
    assign wr_tick  = access & pwrite & hit_tick & pstrb[0];

    // Status word
    always_comb begin
        stat_word = '0;
        stat_word[dfc_pkg::STAT_HALTED] = (state_q == dfc_pkg::DFC_HALTED);
        stat_word[dfc_pkg::STAT_DRAIN]  = (state_q == dfc_pkg::DFC_DRAIN);
        stat_word[dfc_pkg::STAT_MASK]   = halt_q;
    end

    // Control registers
    always_comb begin
        halt_d = halt_q;
        sel_d  = sel_q;
        if (wr_halt) begin
            halt_d = pwdata[dfc_pkg::HALT_BIT]; // [RULE6]
        end
        if (wr_tick) begin
            sel_d = pwdata[dfc_pkg::SEL_W-1:0]; // [RULE8]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_q <= dfc_pkg::HALT_RST; // [RULE6]
            sel_q  <= dfc_pkg::SEL_RST; // [RULE8]
        end else begin
            halt_q <= halt_d;
            sel_q  <= sel_d;
        end
    end

    // Read data prepared in the setup cycle
    always_comb begin
        rdata_d  = rdata_q;
        slverr_d = slverr_q;
        if (setup) begin
            rdata_d  = '0;
            slverr_d = ~(hit_halt | hit_tick | hit_stat);
            if (hit_halt) begin
                rdata_d[dfc_pkg::HALT_BIT] = halt_q;
            end
            if (hit_tick) begin
                rdata_d[dfc_pkg::SEL_W-1:0] = sel_q;
            end
            if (hit_stat) begin
                rdata_d[dfc_pkg::REG_W-1:0] = stat_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q  <= '0;
            slverr_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    assign pready  = pclken;
    assign prdata  = (psel & penable & ~pwrite) ? rdata_q : '0;
    assign pslverr = psel & penable & slverr_q;

    // Halt sequencer
    always_comb begin
        state_d = state_q;
        if (pclken) begin
            case (state_q)
                dfc_pkg::DFC_RUN: begin
                    if (halt_q && core_busy) begin
                        state_d = dfc_pkg::DFC_DRAIN; // [RULE1]
                    end else if (halt_q) begin
                        state_d = dfc_pkg::DFC_HALTED;
                    end
                end
                dfc_pkg::DFC_DRAIN: begin
                    if (!halt_q) begin
                        state_d = dfc_pkg::DFC_RUN;
                    end else if (!core_busy) begin
                        state_d = dfc_pkg::DFC_HALTED; // [RULE1]
                    end
                end
                dfc_pkg::DFC_HALTED: begin
                    if (!halt_q) begin
                        state_d = dfc_pkg::DFC_RUN;
                    end
                end
                default: begin
                    state_d = dfc_pkg::DFC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= dfc_pkg::DFC_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Core control levels
    always_comb begin
        core_ctl.irq_mask = halt_q | (state_q == dfc_pkg::DFC_HALTED); // [RULE4] [RULE6]
        core_ctl.run_en   = (state_q != dfc_pkg::DFC_HALTED); // [RULE5]
        core_ctl.audio_en = (state_q != dfc_pkg::DFC_HALTED); // [RULE5]
    end

    assign core_halted = (state_q == dfc_pkg::DFC_HALTED);

    // Tick source selection
    dfc_tick_mux u_mux (
        .sel  (sel_q),
        .src  (tick_src),
        .tick (sel_tick)
    );

    // Frame tick and masked frame interrupt
    always_comb begin
        tick_d = tick_q;
        irq_d  = irq_q;
        if (pclken) begin
            tick_d = sel_tick; // [RULE7] [RULE14]
            irq_d  = sel_tick & ~halt_q; // [RULE4]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            tick_q <= tick_d;
            irq_q  <= irq_d;
        end
    end

    assign frame_tick     = tick_q;
    assign core_frame_irq = irq_q;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_halt_busy;
        pclken && halt_q && core_busy && state_q == dfc_pkg::DFC_RUN;
    endsequence

    sequence s_drain_done;
        pclken && halt_q && !core_busy && state_q == dfc_pkg::DFC_DRAIN;
    endsequence

    a_halt_waits_frame: assert property ( // [RULE1]
        s_halt_busy |=> state_q == dfc_pkg::DFC_DRAIN && !core_halted)
        else $error("halt entered while core busy");

    a_drain_then_halt: assert property ( // [RULE1]
        s_drain_done |=> core_halted && !core_ctl.run_en)
        else $error("halt not entered after frame finished");

    a_irq_masked: assert property ( // [RULE4]
        pclken && halt_q |=> !core_frame_irq)
        else $error("frame interrupt while masked");

    a_halt_gates_audio: assert property ( // [RULE5]
        core_halted |-> !core_ctl.audio_en && !core_ctl.run_en && core_ctl.irq_mask)
        else $error("audio or core active while halted");

    a_halt_bit_write: assert property ( // [RULE6]
        wr_halt |=> halt_q == $past(pwdata[0]) && core_ctl.irq_mask == (halt_q || core_halted))
        else $error("halt bit write not taken");

    a_tick_follows: assert property ( // [RULE7]
        pclken |=> frame_tick == $past(sel_tick))
        else $error("frame tick does not follow source");

    a_sel_write: assert property ( // [RULE8]
        wr_tick |=> sel_q == $past(pwdata[4:0]))
        else $error("source select write not taken");

    a_cg1_pick: assert property ( // [RULE9]
        sel_q < dfc_pkg::CODE_CG2_LO |-> sel_tick == tick_src.cg1[sel_q[2:0]])
        else $error("first generator tick mismatch");

    a_cg2_pick: assert property ( // [RULE10] [RULE16]
        sel_q >= dfc_pkg::CODE_CG2_LO && sel_q < dfc_pkg::CODE_IN_LO
        |-> sel_tick == tick_src.cg2[2'(sel_q - dfc_pkg::CODE_CG2_LO)])
        else $error("second generator tick mismatch");

    a_in_port_pick: assert property ( // [RULE11]
        sel_q >= dfc_pkg::CODE_IN_LO && sel_q < dfc_pkg::CODE_OUT_LO
        |-> sel_tick == tick_src.in_port[sel_q[1:0]])
        else $error("input port tick mismatch");

    a_out_port_pick: assert property ( // [RULE12] [RULE14]
        sel_q >= dfc_pkg::CODE_OUT_LO && sel_q < dfc_pkg::CODE_SPDIF
        |-> sel_tick == tick_src.out_port[sel_q[1:0]])
        else $error("output port tick mismatch");

    a_spdif_pick: assert property ( // [RULE13]
        sel_q == dfc_pkg::CODE_SPDIF |-> sel_tick == tick_src.spdif)
        else $error("spdif tick mismatch");

    a_reserved_quiet: assert property ( // [RULE17]
        sel_q > dfc_pkg::CODE_SPDIF |-> !sel_tick)
        else $error("reserved code gave a tick");

    a_stall_holds: assert property (
        !pclken |=> $stable(state_q) && $stable(halt_q) && $stable(sel_q) && $stable(frame_tick))
        else $error("state moved while clock enable low");

    a_clear_resumes: assert property ( // [RULE6]
        pclken && !halt_q && state_q != dfc_pkg::DFC_RUN |=> state_q == dfc_pkg::DFC_RUN)
        else $error("halt clear did not resume");

    a_idle_halt: assert property ( // [RULE5]
        pclken && halt_q && !core_busy && state_q == dfc_pkg::DFC_RUN |=> core_halted && !core_ctl.audio_en)
        else $error("idle halt not entered");

    a_halt_hold: assert property ( // [RULE6]
        !wr_halt |=> halt_q == $past(halt_q))
        else $error("halt bit changed without a write");

endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the frame control block: registers, tick selection and halt
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                           pclk;
    logic                           presetn;
    logic                           pclken;
    logic                           psel;
    logic                           penable;
    logic                           pwrite;
    logic [dfc_pkg::ADDR_W-1:0]     paddr;
    logic [dfc_pkg::DATA_W-1:0]     pwdata;
    logic [3:0]                     pstrb;
    logic [dfc_pkg::DATA_W-1:0]     prdata;
    logic                           pready;
    logic                           pslverr;
    logic                           core_busy;
    dfc_pkg::dfc_tick_src_t         tick_src;
    logic                           frame_tick;
    logic                           core_frame_irq;
    dfc_pkg::dfc_core_ctl_t         core_ctl;
    logic                           core_halted;
    int                             seed;
    int                             mismatches;
    int                             num_checks;
    int                             m_code;
    logic                           m_halt;
    logic [31:0]                    r;
    logic                           e;
    int                             n;

    dfc_top i_dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_busy(core_busy), .tick_src(tick_src), .frame_tick(frame_tick),
        .core_frame_irq(core_frame_irq), .core_ctl(core_ctl), .core_halted(core_halted));

    always #2.5 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d, input logic [3:0] st);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'h1;
        // Answer taken at the rising edge that sees ready high
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [19:0] a, input logic [31:0] exp, input logic experr);
        apb(1'h0, a, 32'h0, 4'hF);
        chk(r, exp, "read data");
        chk(32'(e), 32'(experr), "slave error");
    endtask

    // Reference selection: codes map onto the generator and port outputs in table order
    function automatic logic model_tick(input int c, input dfc_pkg::dfc_tick_src_t s);
        if (c < 5) return s.cg1[c];
        if (c < 8) return s.cg2[c-5];
        if (c < 12) return s.in_port[c-8];
        if (c < 16) return s.out_port[c-12];
        if (c == 16) return s.spdif;
        return 1'h0;
    endfunction

    task automatic run_ticks(input int cnt);
        dfc_pkg::dfc_tick_src_t prev;
        logic [31:0]            rv;
        logic                   ex;
        prev = tick_src;
        repeat (cnt) begin
            @(posedge pclk);
            rv = $random(seed);
            tick_src <= rv[16:0];
            @(negedge pclk);
            ex = model_tick(m_code, prev);
            chk(32'(frame_tick), 32'(ex), "frame tick");
            chk(32'(core_frame_irq), 32'(ex & ~m_halt), "frame irq");
            chk(32'(core_ctl.irq_mask), 32'(m_halt), "irq mask");
            prev = tick_src;
        end
        @(posedge pclk);
        tick_src <= '0;
    endtask

    initial begin
        #200000;
        mismatches++;
        test_done();
    end

    initial begin
        seed = 66815;
        mismatches = 0;
        num_checks = 0;
        pclk = 1'h0;
        presetn = 1'h0;
        pclken = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        core_busy = 1'h0;
        tick_src = '0;
        m_halt = 1'h0;
        m_code = 2;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(negedge pclk);
        chk(32'(core_ctl), 32'h6, "core control after reset");
        run_ticks(4);
        rd(dfc_pkg::ADDR_HALT, 32'h0, 1'h0);
        rd(dfc_pkg::ADDR_TICK, 32'h2, 1'h0);
        rd(20'h00010, 32'h0, 1'h1);
        rd(dfc_pkg::ADDR_STAT, 32'h0, 1'h0);
        apb(1'h1, dfc_pkg::ADDR_STAT, 32'hFFFFFFFF, 4'hF);
        chk(32'(e), 32'h0, "status write error");
        apb(1'h1, dfc_pkg::ADDR_HALT, 32'h1, 4'hE);
        rd(dfc_pkg::ADDR_HALT, 32'h0, 1'h0);
        // Every code, with noise in the upper bits
        for (int c = 0; c < 32; c++) begin
            r = $random(seed);
            apb(1'h1, dfc_pkg::ADDR_TICK, {r[31:5], 5'(c)}, 4'hF);
            m_code = c;
            rd(dfc_pkg::ADDR_TICK, 32'(c), 1'h0);
            run_ticks(6);
        end
        // Halt requested while the core is busy
        core_busy <= 1'h1;
        apb(1'h1, dfc_pkg::ADDR_HALT, 32'hFFFFFFFF, 4'hF);
        m_halt = 1'h1;
        repeat (4) begin
            @(negedge pclk);
            chk(32'(core_ctl), 32'h7, "control while draining");
            chk(32'(core_halted), 32'h0, "halted while busy");
        end
        rd(dfc_pkg::ADDR_STAT, 32'h6, 1'h0);
        @(posedge pclk);
        core_busy <= 1'h0;
        n = 0;
        while (core_halted !== 1'h1 && n < 4) begin
            @(negedge pclk);
            n++;
        end
        chk(32'(core_halted), 32'h1, "halted after drain");
        chk(32'(core_ctl), 32'h1, "control while halted");
        rd(dfc_pkg::ADDR_STAT, 32'h5, 1'h0);
        rd(dfc_pkg::ADDR_HALT, 32'h1, 1'h0);
        apb(1'h1, dfc_pkg::ADDR_TICK, 32'h2, 4'hF);
        m_code = 2;
        run_ticks(8);
        apb(1'h1, dfc_pkg::ADDR_HALT, 32'h0, 4'hF);
        m_halt = 1'h0;
        repeat (2) @(negedge pclk);
        chk(32'(core_ctl), 32'h6, "control after resume");
        chk(32'(core_halted), 32'h0, "running after resume");
        run_ticks(4);
        // Halt requested while the core is idle
        apb(1'h1, dfc_pkg::ADDR_HALT, 32'h1, 4'hF);
        @(negedge pclk);
        chk(32'(core_halted), 32'h0, "halted before next edge");
        @(negedge pclk);
        chk(32'(core_ctl), 32'h1, "control after idle halt");
        // Clock enable low stalls the bus answer and freezes the tick
        @(posedge pclk);
        pclken   <= 1'h0;
        tick_src <= '1;
        @(negedge pclk);
        chk(32'(pready), 32'h0, "ready while stalled");
        @(negedge pclk);
        chk(32'(frame_tick), 32'h0, "tick while stalled");
        @(posedge pclk);
        pclken   <= 1'h1;
        tick_src <= '0;
        test_done();
    end
endmodule
